// ### hw/shs_consts.vh
// constants for the host status register block
`ifndef SHS_CONSTS_VH
`define SHS_CONSTS_VH
`define SHS_HOST_STATUS_OFS   8'h00
`define SHS_HOST_STATUS_RST   8'h00
`define SHS_BIT_BUSY          0
`define SHS_BIT_DONE          1
`define SHS_BIT_TGT_ERR       2
`define SHS_BIT_BUS_ERR       3
`define SHS_BIT_FAILED        4
`define SHS_BIT_ALERT         5
`define SHS_BIT_SEMA          6
`define SHS_BIT_BYTE          7
`define SHS_IRQ_MASK          8'h3E
`endif

// ### hw/shs_host_status.v
// status register of the smbus host controller
`timescale 1ns/1ns
`include "shs_consts.vh"
// Functional notes
// - after reset the semaphore reads 0 once; that read arms it to 1
// - writing 1 makes the next semaphore read 0; writing 0 does nothing
// - alert flag sets when alert pin interrupts; never in gpio mode
// - alert flag clears only by write-1 or resume reset low
// - failed flag sets when software terminates a host transaction
// - bus error flag sets on a collision during a host transaction
// - failed and bus error flags clear by writing 1
// - target error sets on illegal command, unclaimed cycle or timeout
// - writing 1 clears target error and drops the request
// - done flag sets only when a command terminates successfully
// - done flag sets regardless of interrupt enable; polling works
// - writing 1 clears done flag and drops the request
// - busy reads 1 while a command runs, cleared on completion
// - writing 0 to any status bit leaves it unchanged
module shs_host_status (
  input  wire       clk,
  input  wire       resetn,
  input  wire       resume_reset_n,
  input  wire [7:0] reg_addr,
  input  wire       reg_rd,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire       alert_pin_n,
  input  wire       alert_is_gpio,
  input  wire       alert_enable,
  input  wire       irq_enable,
  input  wire       mgmt_route,
  input  wire       cmd_start,
  input  wire       cmd_done_ok,
  input  wire       cmd_kill,
  input  wire       cmd_collision,
  input  wire       cmd_illegal,
  input  wire       cmd_unclaimed,
  input  wire       cmd_timeout,
  input  wire       byte_done,
  output wire       host_busy,
  output wire       irq,
  output wire       mgmt_irq_n
);
  reg        sema_ff;
  reg        busy_ff;
  reg        done_ff;
  reg        tgt_err_ff;
  reg        bus_err_ff;
  reg        failed_ff;
  reg        byte_ff;
  reg        alert_ff;
  reg        alert_prev_ff;
  reg        req_ff;
  wire       alert_s;
  wire       sel;
  wire       rd_hit;
  wire       wr_hit;
  wire [7:0] wclr;
  wire       alert_edge;
  wire [7:0] status;

  // alert pin is asynchronous to clk
  shs_sync u_alert_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      (~alert_pin_n),
    .q      (alert_s)
  );

  assign sel    = (reg_addr == `SHS_HOST_STATUS_OFS);
  assign rd_hit = sel & reg_rd;
  assign wr_hit = sel & reg_wr;
  assign wclr   = wr_hit ? reg_wdata : 8'h00;
  assign alert_edge = alert_s & ~alert_prev_ff & alert_enable & ~alert_is_gpio;

  assign status = {byte_ff, sema_ff, alert_ff, failed_ff, bus_err_ff,
                   tgt_err_ff, done_ff, busy_ff};

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alert_prev_ff <= 1'b0;
    end else begin
      alert_prev_ff <= alert_s;
    end
  end

  // semaphore: read returns current value, then arms to 1
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sema_ff <= 1'b0;
    end else if (wclr[`SHS_BIT_SEMA]) begin
      sema_ff <= 1'b0;
    end else if (rd_hit) begin
      sema_ff <= 1'b1;
    end
  end

  // alert flag lives in the resume well, not the main reset
  always @(posedge clk or negedge resume_reset_n) begin
    if (!resume_reset_n) begin
      alert_ff <= 1'b0;
    end else if (alert_edge) begin
      alert_ff <= 1'b1;
    end else if (wclr[`SHS_BIT_ALERT]) begin
      alert_ff <= 1'b0;
    end
  end

  // a flag set wins over a write-1 clear in the same cycle; for busy, completion wins over start
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_ff    <= 1'b0;
      done_ff    <= 1'b0;
      tgt_err_ff <= 1'b0;
      bus_err_ff <= 1'b0;
      failed_ff  <= 1'b0;
      byte_ff    <= 1'b0;
    end else begin
      // an illegal command runs nothing, so it must not leave busy stuck high
      if (cmd_done_ok | cmd_kill | cmd_collision | cmd_illegal | cmd_unclaimed | cmd_timeout)
        busy_ff <= 1'b0;
      else if (cmd_start & ~cmd_illegal)
        busy_ff <= 1'b1;
      if (cmd_done_ok)
        done_ff <= 1'b1;
      else if (wclr[`SHS_BIT_DONE])
        done_ff <= 1'b0;
      if (cmd_illegal | cmd_unclaimed | cmd_timeout)
        tgt_err_ff <= 1'b1;
      else if (wclr[`SHS_BIT_TGT_ERR])
        tgt_err_ff <= 1'b0;
      if (cmd_collision)
        bus_err_ff <= 1'b1;
      else if (wclr[`SHS_BIT_BUS_ERR])
        bus_err_ff <= 1'b0;
      if (cmd_kill)
        failed_ff <= 1'b1;
      else if (wclr[`SHS_BIT_FAILED])
        failed_ff <= 1'b0;
      if (byte_done)
        byte_ff <= 1'b1;
      else if (wclr[`SHS_BIT_BYTE])
        byte_ff <= 1'b0;
    end
  end

  // completion flag needs irq_enable to raise a request; alert has its own enable
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      req_ff <= 1'b0;
    end else begin
      req_ff <= (irq_enable & (done_ff | tgt_err_ff | bus_err_ff | failed_ff))
                | alert_ff;
    end
  end

  assign host_busy  = busy_ff;
  assign irq        = req_ff & ~mgmt_route;
  assign mgmt_irq_n = ~(req_ff & mgmt_route);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= `SHS_HOST_STATUS_RST;
    end else if (rd_hit) begin
      reg_rdata <= status;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

// ### hw/shs_sync.v
// two flip-flop synchroniser for a level input
`timescale 1ns/1ns
module shs_sync (
  input  wire clk,
  input  wire resetn,
  input  wire d,
  output wire q
);
  reg meta_ff;
  reg sync_ff;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end
  assign q = sync_ff;
endmodule

// ### sim/shs_checker.sv
// assertions on the host status ports
`timescale 1ns/1ns
module shs_checker (
  input wire       clk,
  input wire       resetn,
  input wire [7:0] reg_addr,
  input wire       reg_rd,
  input wire       reg_wr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire       irq_enable,
  input wire       mgmt_route,
  input wire       cmd_start,
  input wire       cmd_done_ok,
  input wire       cmd_kill,
  input wire       cmd_illegal,
  input wire       host_busy,
  input wire       irq,
  input wire       mgmt_irq_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire rd0 = reg_rd && reg_addr == 8'h00;
  wire wr0 = reg_wr && reg_addr == 8'h00;
  a_busy_set: assert property (cmd_start && !cmd_illegal |=> host_busy)
    else $error("busy not set");
  a_busy_clr: assert property (cmd_done_ok && !cmd_start |=> !host_busy)
    else $error("busy not cleared");
  a_done_irq: assert property (cmd_done_ok ##2 irq_enable |=> irq || mgmt_route)
    else $error("no request on done");
  a_kill_irq: assert property (cmd_kill ##2 irq_enable |=> irq || !mgmt_irq_n)
    else $error("no request on kill");
  a_one_path: assert property (!(irq && !mgmt_irq_n))
    else $error("both request paths active");
  a_sema_arm: assert property (rd0 && !reg_wr ##1 rd0 && !reg_wr |=> reg_rdata[6])
    else $error("semaphore not armed");
  a_sema_clr: assert property (wr0 && reg_wdata[6] ##1 rd0 && !reg_wr |=> !reg_rdata[6])
    else $error("semaphore not released");
  a_zero_keep: assert property (irq && wr0 && reg_wdata == 8'h00 ##1 irq_enable && !mgmt_route
    |=> irq)
    else $error("zero write dropped request");
  cover property (rd0 ##1 rd0);
  cover property (cmd_kill ##2 irq);
  cover property (mgmt_route && !mgmt_irq_n);
endmodule

// ### sim/shs_tgt_model.sv
// alert pin of a target device on the two-wire bus
`timescale 1ns/1ns
module shs_tgt_model (
  input  wire pull,
  output wire alert_pin_n
);
  // open drain with pull-up: a released pin reads high, never a stale level
  assign alert_pin_n = pull ? 1'b0 : 1'b1;
endmodule

// ### sim/tb_top.sv
// self-checking bench for the host status register
`timescale 1ns/1ns
module tb_top;
  reg        clk = 0, resetn = 0, rsn = 0, rd = 0, wr = 0, st = 0, ie = 1, mr = 0, gp = 0;
  reg        pull = 0;
  reg  [7:0] a = 8'h00, wd = 8'h00, q;
  reg  [5:0] ev = 6'h00;
  wire [7:0] rdata;
  wire       busy, irq, mirq_n, alert_n;
  integer    n_fail = 0, samples_checked = 0, i;
  always #50 clk = ~clk;
  shs_tgt_model i_shs_tgt_model (.pull(pull), .alert_pin_n(alert_n));
  shs_host_status i_shs_host_status (.clk(clk), .resetn(resetn), .resume_reset_n(rsn),
    .reg_addr(a), .reg_rd(rd), .reg_wr(wr), .reg_wdata(wd), .reg_rdata(rdata),
    .alert_pin_n(alert_n), .alert_is_gpio(gp), .alert_enable(1'b1), .irq_enable(ie),
    .mgmt_route(mr), .cmd_start(st), .cmd_done_ok(ev[5]), .cmd_kill(ev[0]),
    .cmd_collision(ev[1]), .cmd_illegal(ev[2]), .cmd_unclaimed(ev[3]), .cmd_timeout(ev[4]),
    .byte_done(1'b0), .host_busy(busy), .irq(irq), .mgmt_irq_n(mirq_n));
  task chk(input [7:0] g, input [7:0] e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rdr(input [7:0] ad);
    @(posedge clk) rd <= 1'b1;
    a <= ad;
    @(posedge clk) rd <= 1'b0;
    #1 q = rdata;
  endtask
  task wrr(input [7:0] d);
    @(posedge clk) wr <= 1'b1;
    wd <= d;
    a <= 8'h00;
    @(posedge clk) wr <= 1'b0;
  endtask
  function [7:0] ex(input integer k);
    ex = k == 0 ? 8'h10 : k == 1 ? 8'h08 : k == 5 ? 8'h02 : 8'h04;
  endfunction
  task t_sema;
    rdr(8'h00);
    chk(q, 8'h00);
    rdr(8'h00);
    chk(q, 8'h40);
    wrr(8'h00);
    rdr(8'h00);
    chk(q, 8'h40);
    wrr(8'h40);
    rdr(8'h00);
    chk(q, 8'h00);
  endtask
  task t_ev;
    for (i = 0; i < 6; i = i + 1) begin
      @(posedge clk) st <= 1'b1;
      ie <= (i < 5);
      @(posedge clk) st <= 1'b0;
      #1 chk({7'h00, busy}, 8'h01);
      @(posedge clk) ev <= 6'h01 << i;
      @(posedge clk) ev <= 6'h00;
      wrr(8'h00);
      rdr(8'h00);
      chk(q, 8'h40 | ex(i));
      chk({7'h00, irq}, {7'h00, ie});
      @(posedge clk) mr <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk({7'h00, mirq_n}, {7'h00, !ie});
      @(posedge clk) mr <= 1'b0;
      wrr(ex(i));
      rdr(8'h00);
      chk(q, 8'h40);
      chk({7'h00, irq}, 8'h00);
    end
  endtask
  task t_alert;
    gp <= 1'b1;
    @(posedge clk) pull <= 1'b1;
    repeat (4) @(posedge clk);
    pull <= 1'b0;
    rdr(8'h00);
    chk(q, 8'h40);
    @(posedge clk) gp <= 1'b0;
    pull <= 1'b1;
    repeat (4) @(posedge clk);
    pull <= 1'b0;
    wrr(8'h00);
    rdr(8'h00);
    chk(q, 8'h60);
    @(posedge clk) rsn <= 1'b0;
    @(posedge clk) rsn <= 1'b1;
    rdr(8'h00);
    chk(q, 8'h40);
  endtask
  task close_out;
    $display("n_fail %0d samples_checked %0d", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rsn <= 1'b1;
    t_sema;
    t_ev;
    t_alert;
    rdr(8'h05);
    chk(q, 8'h00);
    close_out;
  end
  // generous margin: the whole sequence needs well under 400 cycles
  initial begin
    #100000;
    n_fail = n_fail + 1;
    close_out;
  end
endmodule
bind shs_host_status shs_checker i_shs_checker (.*);
